//--- bench/ircc_host.sv
`timescale 1ns/1ps
module ircc_host
    import ircc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic [DATA_W-1:0] REG_RDATA,
    output logic REG_WR,
    output logic REG_RD,
    output logic [ADDR_W-1:0] REG_ADDR,
    output logic [DATA_W-1:0] REG_WDATA
);
    initial begin
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    end
    // data inverted after release so a stale sample cannot pass for a fresh one
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge CLOCK);
        #2 {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
        @(posedge CLOCK);
        #2 {REG_WR, REG_RD, REG_WDATA} = {2'b00, ~d};
        q = REG_RDATA;
    endtask
endmodule

//--- bench/ircc_regs_asserts.sv
`timescale 1ns/1ps
module ircc_regs_chk
    import ircc_pkg::*;
(
    input wire logic CLOCK, RESET, REG_WR, REG_RD, CONV_DONE, RESULT_READ, CFG_CRC_ERR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA, REG_RDATA,
    input wire logic READ_CRC_EN, OFFSET_CAL_EN, GAIN_CAL_EN, QUICK_CMD_EN, RESULT_FROM_MOD,
    input wire logic [5:0] READ_CRC_LEN,
    input wire logic IRQ_PIN_O, IRQ_PIN_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    wire wr_cfg = REG_WR && REG_ADDR == CFG3_ADDR;
    wire wr_irq = REG_WR && REG_ADDR == IRQ_ADDR;
    a_crc_width: assert property (wr_cfg |=>
        READ_CRC_LEN == ($past(REG_WDATA[3]) ? CRC_LEN_WIDE : CRC_LEN_NARROW)) else $error("len");
    a_crc_enable: assert property (wr_cfg |=>
        READ_CRC_EN == $past(REG_WDATA[2])) else $error("crc enable");
    a_cal_enables: assert property (wr_cfg |=>
        {OFFSET_CAL_EN, GAIN_CAL_EN} == $past(REG_WDATA[1:0])) else $error("cal enables");
    a_quick_cmd: assert property (wr_irq |=>
        QUICK_CMD_EN == $past(REG_WDATA[1])) else $error("quick command");
    a_mod_result: assert property (wr_irq |=>
        RESULT_FROM_MOD == $past(REG_WDATA[3])) else $error("result source");
    a_top_zero: assert property (REG_RD |=> !REG_RDATA[7]) else $error("top bit");
    a_mod_drive: assert property (RESULT_FROM_MOD [*2] |-> IRQ_PIN_OE)
        else $error("bitstream pin released");
    a_crc_err_pin: assert property (CFG_CRC_ERR |-> ##2
        (IRQ_PIN_OE && !IRQ_PIN_O)) else $error("crc error not on pin");
    a_ready_pin: assert property (CONV_DONE && !RESULT_FROM_MOD
        ##1 !RESULT_READ && !RESULT_FROM_MOD |=> !IRQ_PIN_O) else $error("ready not on pin");
    c_ready: cover property (CONV_DONE);
    c_crc: cover property (CFG_CRC_ERR);
    c_mod: cover property (wr_irq && REG_WDATA[3]);
endmodule
////////////////////////////////////////////////////////////
bind ircc_regs ircc_regs_chk ircc_regs_chk_inst (.*);

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ircc_pkg::*;
    logic clock = 1'b0, reset = 1'b1, cd = 1'b0, rr = 1'b0, ce = 1'b0, cs = 1'b0, mb = 1'b0;
    logic wr, rd, crc_en, off_en, gain_en, quick, from_mod, pin_o, pin_oe;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, q;
    logic [5:0] crc_len;
    int n_fail = 0, checks_done = 0, cycles = 0;
    ircc_host host(.CLOCK(clock), .REG_RDATA(rdata), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata));
    ircc_regs ircc_regs_inst(.CLOCK(clock), .RESET(reset), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .CONV_DONE(cd), .RESULT_READ(rr), .CFG_CRC_ERR(ce),
        .CONV_START(cs), .MOD_BIT(mb), .REG_RDATA(rdata), .READ_CRC_EN(crc_en),
        .READ_CRC_LEN(crc_len), .OFFSET_CAL_EN(off_en), .GAIN_CAL_EN(gain_en),
        .QUICK_CMD_EN(quick), .RESULT_FROM_MOD(from_mod), .IRQ_PIN_O(pin_o), .IRQ_PIN_OE(pin_oe));
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        host.acc(1'b0, a, 8'h00, q);
        chk("rdata", {8'h00, exp}, {8'h00, q});
    endtask
    task t_defaults;
        rd_chk(IRQ_ADDR, 8'h63);
        rd_chk(IRQ_ADDR, 8'h73);
        rd_chk(CFG3_ADDR, 8'h00);
        chk("cfg", 9'h080, {crc_len, crc_en, off_en, gain_en});
        chk("pin", 2'b01, {pin_oe, pin_o});
    endtask
    task t_cfg;
        host.acc(1'b1, CFG3_ADDR, 8'hfa, q);
        rd_chk(CFG3_ADDR, 8'h0a);
        chk("cfg", 9'h102, {crc_len, crc_en, off_en, gain_en});
        host.acc(1'b1, CFG3_ADDR, 8'h05, q);
        chk("cfg", 9'h085, {crc_len, crc_en, off_en, gain_en});
    endtask
    task t_irq;
        host.acc(1'b1, IRQ_ADDR, 8'hf0, q);
        rd_chk(IRQ_ADDR, 8'h70);
        chk("quick", 1'b0, quick);
        host.acc(1'b1, IRQ_ADDR, 8'h04, q);
        cs = 1'b1;
        cyc(1);
        chk("pin", 2'b11, {pin_oe, pin_o});
        cs = 1'b0;
        host.acc(1'b1, IRQ_ADDR, 8'h07, q);
        cs = 1'b1;
        cyc(1);
        chk("pin", 2'b10, {pin_oe, pin_o});
        cs = 1'b0;
        chk("quick", 1'b1, quick);
    endtask
    task t_ready;
        cd = 1'b1;
        cyc(1);
        cd = 1'b0;
        cyc(1);
        chk("pin", 2'b10, {pin_oe, pin_o});
        rd_chk(IRQ_ADDR, 8'h37);
        rr = 1'b1;
        cyc(1);
        rr = 1'b0;
        rd_chk(IRQ_ADDR, 8'h77);
    endtask
    // ready is left pending here, so the bitstream has to win over it
    task t_mod;
        mb = 1'b1;
        host.acc(1'b1, IRQ_ADDR, 8'h0b, q);
        cd = 1'b1;
        cyc(1);
        cd = 1'b0;
        cyc(1);
        chk("mod", 3'b111, {from_mod, pin_oe, pin_o});
        mb = 1'b0;
        cyc(3);
        chk("mod", 3'b110, {from_mod, pin_oe, pin_o});
        mb = 1'b1;
        ce = 1'b1;
        cyc(1);
        ce = 1'b0;
        cyc(3);
        chk("mod", 3'b110, {from_mod, pin_oe, pin_o});
        rd_chk(IRQ_ADDR, 8'h1b);
        rd_chk(4'h9, 8'h00);
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #2 reset = 1'b0;
        t_defaults();
        t_cfg();
        t_irq();
        t_ready();
        t_mod();
        end_sim();
    end
endmodule

//--- include/ircc_pkg.sv
package ircc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] CFG3_ADDR = 4'h4;
    localparam logic [3:0] IRQ_ADDR = 4'h5;
    // configuration register 3 fields (low nibble only)
    localparam int CRC_WIDE_BIT = 3;
    localparam int READ_CRC_EN_BIT = 2;
    localparam int OFFSET_CAL_BIT = 1;
    localparam int GAIN_CAL_BIT = 0;
    localparam logic [3:0] CFG3_RESET = 4'h0;
    // interrupt status/control fields
    localparam int IRQ_UNIMPL_BIT = 7;
    localparam int CONV_READY_BIT = 6;
    localparam int CFG_CRC_BIT = 5;
    localparam int POR_FLAG_BIT = 4;
    localparam int PIN_MODE_HI_BIT = 3;
    localparam int PIN_MODE_LO_BIT = 2;
    localparam int QUICK_CMD_BIT = 1;
    localparam int CONV_START_BIT = 0;
    localparam logic [1:0] PIN_MODE_RESET = 2'h0;
    localparam logic QUICK_CMD_RESET = 1'b1;
    localparam logic CONV_START_RESET = 1'b1;
    localparam logic CONV_READY_RESET = 1'b1;
    localparam logic CFG_CRC_RESET = 1'b1;
    localparam logic POR_FLAG_RESET = 1'b0;
    // crc trailer lengths on read transfers
    localparam logic [5:0] CRC_LEN_NARROW = 6'h10;
    localparam logic [5:0] CRC_LEN_WIDE = 6'h20;
endpackage

//--- rtl/ircc_regs.sv
`timescale 1ns/1ps
// Functional notes
// - crc width bit set: crc-16 plus sixteen zeros; clear: crc-16 only.
// - read crc appended only while enable bit set; reset clear.
// - offset calibration applied only while its enable bit is set; reset off.
// - gain calibration applied only while its enable bit is set; reset off.
// - conversion ready flag low when new result waits, high after read/reset.
// - config crc error flag high by default, low once an error occurred.
// - upper pin mode bit: pin carries bitstream; por/crc interrupts override it.
// - lower pin mode bit: inactive pin driven high if set, released if clear.
// - quick commands accepted only while enable bit set; set by default.
// - conversion-start interrupt on pin only while its enable is set; default on.
// - upper pin mode bit set: modulator codes also go to result register.
module ircc_regs
    import ircc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic CONV_DONE,
    input wire logic RESULT_READ,
    input wire logic CFG_CRC_ERR,
    input wire logic CONV_START,
    input wire logic MOD_BIT,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic READ_CRC_EN,
    output logic [5:0] READ_CRC_LEN,
    output logic OFFSET_CAL_EN,
    output logic GAIN_CAL_EN,
    output logic QUICK_CMD_EN,
    output logic RESULT_FROM_MOD,
    output logic IRQ_PIN_O,
    output logic IRQ_PIN_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode, used by the config, interrupt control and status flag groups below
    logic wr_cfg3;
    logic wr_irq;
    logic rd_irq;

    always_comb begin
        wr_cfg3 = REG_WR && (REG_ADDR == CFG3_ADDR);
        wr_irq = REG_WR && (REG_ADDR == IRQ_ADDR);
        rd_irq = REG_RD && (REG_ADDR == IRQ_ADDR);
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration register 3: only the low nibble is kept
    logic [3:0] cfg3_r;
    logic [3:0] cfg3_nxt;
    logic [5:0] crc_len_r;
    logic [5:0] crc_len_nxt;

    always_comb begin
        cfg3_nxt = cfg3_r;
        if (wr_cfg3) begin
            // upper bits dropped, they read back as zero
            cfg3_nxt = REG_WDATA[3:0];
        end
        // length follows the next value so both land on one edge
        if (cfg3_nxt[CRC_WIDE_BIT]) begin
            crc_len_nxt = CRC_LEN_WIDE;
        end else begin
            crc_len_nxt = CRC_LEN_NARROW;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfg3_r <= CFG3_RESET;
            // width bit resets clear
            crc_len_r <= CRC_LEN_NARROW;
        end else begin
            cfg3_r <= cfg3_nxt;
            crc_len_r <= crc_len_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt control bits, host writable
    logic [1:0] pin_mode_r;
    logic [1:0] pin_mode_nxt;
    logic quick_cmd_r;
    logic quick_cmd_nxt;
    logic start_en_r;
    logic start_en_nxt;

    always_comb begin
        pin_mode_nxt = pin_mode_r;
        quick_cmd_nxt = quick_cmd_r;
        start_en_nxt = start_en_r;
        if (wr_irq) begin
            // status flags and top bit are not writable
            pin_mode_nxt = REG_WDATA[PIN_MODE_HI_BIT:PIN_MODE_LO_BIT];
            quick_cmd_nxt = REG_WDATA[QUICK_CMD_BIT];
            start_en_nxt = REG_WDATA[CONV_START_BIT];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pin_mode_r <= PIN_MODE_RESET;
            quick_cmd_r <= QUICK_CMD_RESET;
            start_en_r <= CONV_START_RESET;
        end else begin
            pin_mode_r <= pin_mode_nxt;
            quick_cmd_r <= quick_cmd_nxt;
            start_en_r <= start_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active-low status flags, set and cleared by hardware events; the por flag clears on an interrupt register read
    logic ready_n_r;
    logic ready_n_nxt;
    logic crc_err_n_r;
    logic crc_err_n_nxt;
    logic por_n_r;
    logic por_n_nxt;

    always_comb begin
        // new result wins over a read in the same cycle
        ready_n_nxt = ready_n_r;
        if (RESULT_READ) begin
            ready_n_nxt = 1'b1;
        end
        if (CONV_DONE) begin
            ready_n_nxt = 1'b0;
        end
        // sticky until reset; a config rewrite does not hide a past error
        crc_err_n_nxt = crc_err_n_r;
        if (CFG_CRC_ERR) begin
            crc_err_n_nxt = 1'b0;
        end
        // the read returns the old value, the flag clears behind it
        por_n_nxt = por_n_r;
        if (rd_irq) begin
            por_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ready_n_r <= CONV_READY_RESET;
            crc_err_n_r <= CFG_CRC_RESET;
            por_n_r <= POR_FLAG_RESET;
        end else begin
            ready_n_r <= ready_n_nxt;
            crc_err_n_r <= crc_err_n_nxt;
            por_n_r <= por_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, held until the next read strobe
    logic [DATA_W-1:0] irq_view;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    always_comb begin
        irq_view = '0;
        irq_view[CONV_READY_BIT] = ready_n_r;
        irq_view[CFG_CRC_BIT] = crc_err_n_r;
        irq_view[POR_FLAG_BIT] = por_n_r;
        irq_view[PIN_MODE_HI_BIT] = pin_mode_r[1];
        irq_view[PIN_MODE_LO_BIT] = pin_mode_r[0];
        irq_view[QUICK_CMD_BIT] = quick_cmd_r;
        irq_view[CONV_START_BIT] = start_en_r;
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            unique case (REG_ADDR)
                CFG3_ADDR: rdata_nxt = {4'h0, cfg3_r};
                IRQ_ADDR: rdata_nxt = irq_view;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pin, active low
    logic urgent;
    logic any_irq;
    logic pin_o_r;
    logic pin_o_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;

    always_comb begin
        urgent = !crc_err_n_r || !por_n_r;
        any_irq = urgent || !ready_n_r || (start_en_r && CONV_START);
        if (pin_mode_r[1]) begin
            // bitstream hides ready and start events; only urgent ones show
            pin_o_nxt = urgent ? 1'b0 : MOD_BIT;
            pin_oe_nxt = 1'b1;
        end else if (any_irq) begin
            pin_o_nxt = 1'b0;
            pin_oe_nxt = 1'b1;
        end else begin
            pin_o_nxt = 1'b1;
            pin_oe_nxt = pin_mode_r[0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pin_o_r <= 1'b1;
            pin_oe_r <= 1'b0;
        end else begin
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin output is registered one cycle behind the flags and inputs that drive it, so it leaves a flop cleanly
    assign REG_RDATA = rdata_r;
    assign READ_CRC_EN = cfg3_r[READ_CRC_EN_BIT];
    assign READ_CRC_LEN = crc_len_r;
    assign OFFSET_CAL_EN = cfg3_r[OFFSET_CAL_BIT];
    assign GAIN_CAL_EN = cfg3_r[GAIN_CAL_BIT];
    assign QUICK_CMD_EN = quick_cmd_r;
    assign RESULT_FROM_MOD = pin_mode_r[1];
    assign IRQ_PIN_O = pin_o_r;
    assign IRQ_PIN_OE = pin_oe_r;

endmodule
